/* File: common/addr_filter_consts.svh */
// Offsets, field positions, reset values and counts of the address filter
`ifndef ADDR_FILTER_CONSTS_SVH
`define ADDR_FILTER_CONSTS_SVH

// ****************************************
// Address map
// ****************************************
// Byte offset of the table from the module base; bus word address 0 sits here
`define AF_TABLE_BASE 12'ha00
// Byte stride between two table entries
`define AF_ENTRY_STRIDE 12'h008
// Byte offset of hash mask bytes 0..3 and 4..7
`define AF_MASK_LOW_OFFSET 12'hbf0
`define AF_MASK_HIGH_OFFSET 12'hbf8
// Offsets that stay silent in hash mode
`define AF_HASH_HOLE_0 12'hbf4
`define AF_HASH_HOLE_1 12'hbf6
`define AF_HASH_HOLE_2 12'hbfc
`define AF_HASH_HOLE_3 12'hbfe
// Word within an entry: 0 holds bytes 0/1, 1 bytes 2/3, 2 bytes 4/5, 3 unused
`define AF_WORD_LAST 2'h2
`define AF_WORD_UNUSED 2'h3
// Entries that become the hash mask in hash mode
`define AF_MASK_ENTRY_LOW 6'h3e
`define AF_MASK_ENTRY_HIGH 6'h3f

// ****************************************
// Field positions
// ****************************************
// Byte lane carrying the even (lower-numbered) byte of a word
`define AF_LANE_EVEN 1
`define AF_LANE_ODD 0
// Position of the individual/group bit in the received address
`define AF_IG_BIT 0
// Reason field and index inside the descriptor pointer byte
`define AF_PTR_REASON_MSB 7
`define AF_PTR_REASON_LSB 6

// ****************************************
// Reset values and counts
// ****************************************
`define AF_ENTRY_RESET 48'hffff_ffff_ffff
`define AF_RDATA_RESET 16'h0000
`define AF_CRC_INIT 32'hffff_ffff
`define AF_CRC_POLY 32'h04c1_1db7
// Destination address bits, counted 0..47
`define AF_DEST_BITS 6'd48
`define AF_DEST_LAST 6'd47

// ****************************************
// Decision codes
// ****************************************
`define AF_REASON_NONE 2'b00
`define AF_REASON_GROUP 2'b01
`define AF_REASON_PERFECT 2'b10
`define AF_REASON_HASH 2'b11
`define AF_INDEX_BCAST 6'h3f
`define AF_INDEX_PROMISCUOUS_ENABLE_BCAST 6'h2f
`define AF_INDEX_ZERO 6'h00

`endif

/* File: common/addr_filter_pkg.sv */
// Types shared by the address filter modules
package addr_filter_pkg;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_COLLECT = 2'b01,
		RX_EVAL = 2'b10,
		RX_DONE = 2'b11
	} rx_phase_t;

	typedef struct packed {
		logic running;
		logic [31:0] crc;
	} crc_state_t;

	typedef struct packed {
		logic waitreq;
		logic [15:0] rdata;
		logic [63:0][47:0] table_mem;
		logic [63:0] entry_live;
		rx_phase_t phase;
		logic [5:0] bit_cnt;
		logic [47:0] dest;
		logic dec_valid;
		logic dec_accept;
		logic dec_miss;
		logic [1:0] dec_reason;
		logic [5:0] dec_index;
		logic ptr_write;
		logic [7:0] ptr_byte;
	} filter_state_t;

endpackage

/* File: logic/ethernet_address_filter.sv */
// Receive address recognition: 64-entry table, hash mask and frame decision
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "addr_filter_consts.svh"

// Summary of operation
// RL1: Host reads and writes the table with ordinary word or byte cycles.
// RL2: Unused locations inside the table space never acknowledge a bus cycle.
// RL3: Host writes bytes 4/5 of an entry last; writes carry one or two bytes.
// RL4: Writing an entry's early bytes disables it until byte 5 arrives.
// RL5: Byte 0 bit 0 (word bit 8) compares with the first, I/G, bit.
// RL6: Received bits fill byte 0 bits 0..7 first, then bytes 1..5.
// RL7: Hash mode turns the last two entries into the 64-bit mask.
// RL8: Hash index 0 is mask byte 7 bit 0; index 63 byte 0 bit 7.
// RL9: Mask bytes may be written in any order without disabling anything.
// RL10: In hash mode the four spare words of the mask entries stay silent.
// RL11: Table bytes read back in any order as plain memory.
// RL12: Unicast, no promiscuous, no reject: perfect 10, hash 11, else reject.
// RL13: Unicast with physical reject: perfect rejects, hash 11, miss accepted 00.
// RL14: Promiscuous accepts every unicast frame, flagging misses with reason 00.
// RL15: Broadcast accepted by policy, else only under promiscuous with index 2F.
// RL16: Multicast: policy 11 only promiscuous miss; else perfect 10, hash 11, policy 10 reason 01, else reject or promiscuous miss.
// RL17: Hash index is six top CRC bits after the 48th address bit.
// RL18: A perfect match outranks a hash match.
// RL19: With write-back on, reason and index go to the descriptor pointer byte.
// RL20: Host fills the table before enabling; unused entries ones, mask zeros.
// RL21: Decision, miss, reason and index appear together after the address.
module ethernet_address_filter
	import addr_filter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [15:0] writedata,
	input wire logic [1:0] byteenable,
	output logic [15:0] readdata,
	output logic waitrequest,
	input wire logic controller_enable,
	input wire logic hash_enable,
	input wire logic promiscuous_enable,
	input wire logic physical_reject_enable,
	input wire logic [1:0] group_frame_policy,
	input wire logic index_writeback_enable,
	input wire logic frame_start,
	input wire logic dest_bit_valid,
	input wire logic dest_bit,
	output logic decision_valid,
	output logic frame_accept,
	output logic frame_miss,
	output logic [1:0] accept_reason,
	output logic [5:0] accept_index,
	output logic pointer_write,
	output logic [7:0] pointer_byte
);

	// ****************************************
	// Helpers
	// ****************************************
	// Byte offset from the module base of a bus word address
	function automatic logic [11:0] byte_offset(input logic [7:0] a);
		byte_offset = 12'(`AF_TABLE_BASE + {3'b000, a, 1'b0});
	endfunction

	// Unused words never answer; the spare mask words join them in hash mode
	function automatic logic is_mapped(input logic [7:0] a, input logic hmode);
		logic [11:0] off;
		off = byte_offset(a);
		if (a[1:0] == `AF_WORD_UNUSED) begin
			is_mapped = 1'b0;
		// RL10: hash mode holes
		end else if (hmode && (off == `AF_HASH_HOLE_0 || off == `AF_HASH_HOLE_1)) begin
			is_mapped = 1'b0;
		end else if (hmode && (off == `AF_HASH_HOLE_2 || off == `AF_HASH_HOLE_3)) begin
			is_mapped = 1'b0;
		end else begin
			is_mapped = 1'b1;
		end
	endfunction

	// Entry byte b sits at bits 8b+7..8b, so bit 0 of byte 0 is entry bit 0
	function automatic logic [15:0] entry_word(input logic [47:0] e, input logic [1:0] w);
		logic [2:0] b;
		b = {w[1:0], 1'b0};
		entry_word = {e[8*b +: 8], e[8*(b+3'd1) +: 8]};
	endfunction

	function automatic logic is_mask_entry(input logic [5:0] e);
		is_mask_entry = (e == `AF_MASK_ENTRY_LOW) || (e == `AF_MASK_ENTRY_HIGH);
	endfunction

	filter_state_t s_q;
	filter_state_t s_d;

	logic req;
	logic [5:0] acc_entry;
	logic [1:0] acc_word;
	logic [2:0] even_byte;
	logic [5:0] crc_index;
	logic [7:0] mask_byte;
	logic [2:0] mask_byte_no;
	logic [5:0] mask_entry;
	logic hash_hit;
	logic perfect_hit;
	logic [5:0] perfect_line;
	logic is_broadcast;
	logic is_group;
	logic d_accept;
	logic d_miss;
	logic [1:0] d_reason;
	logic [5:0] d_index;
	logic take_bit;

	assign req = read | write;
	assign acc_entry = address[7:2];
	assign acc_word = address[1:0];
	assign even_byte = {acc_word, 1'b0};
	assign take_bit = dest_bit_valid && s_q.phase == RX_COLLECT && controller_enable;

	// ****************************************
	// Matching
	// ****************************************
	// RL17: hash pointer from the serial CRC
	hash_crc_unit u_crc (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.frame_start(frame_start && controller_enable),
		.bit_take(take_bit),
		.bit_value(dest_bit),
		.hash_index(crc_index)
	);

	// RL8: index 0 is byte 7 bit 0, index 63 byte 0 bit 7
	always_comb begin
		mask_byte_no = 3'd7 - crc_index[5:3];
		mask_entry = mask_byte_no[2] ? `AF_MASK_ENTRY_HIGH : `AF_MASK_ENTRY_LOW;
		mask_byte = s_q.table_mem[mask_entry][8*mask_byte_no[1:0] +: 8];
		hash_hit = hash_enable && mask_byte[crc_index[2:0]];
	end

	// Lowest matching line wins; 64 parallel comparators trade area for speed
	always_comb begin
		perfect_hit = 1'b0;
		perfect_line = 6'h00;
		for (int e = 63; e >= 0; e--) begin
			// RL4: disabled entries never compare
			// RL7: mask entries leave the perfect table in hash mode
			if (s_q.entry_live[e] && !(hash_enable && is_mask_entry(6'(e)))
				&& s_q.table_mem[e] == s_q.dest) begin
				perfect_hit = 1'b1;
				perfect_line = 6'(e);
			end
		end
	end

	// RL5: first received bit is the I/G bit
	assign is_group = s_q.dest[`AF_IG_BIT];
	assign is_broadcast = &s_q.dest;

	filter_decision u_decide (
		.is_broadcast(is_broadcast),
		.is_group(is_group),
		.perfect_hit(perfect_hit),
		.perfect_line(perfect_line),
		.hash_hit(hash_hit),
		.hash_index(crc_index),
		.promiscuous_enable(promiscuous_enable),
		.physical_reject_enable(physical_reject_enable),
		.group_frame_policy(group_frame_policy),
		.accept(d_accept),
		.miss(d_miss),
		.reason(d_reason),
		.index(d_index)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.dec_valid = 1'b0;
		s_d.ptr_write = 1'b0;

		// RL1: answer a mapped cycle one clock after it appears
		// RL2: an unmapped cycle keeps waitrequest high for as long as it is held
		if (!s_q.waitreq) begin
			s_d.waitreq = 1'b1;
		end else if (req && is_mapped(address, hash_enable)) begin
			s_d.waitreq = 1'b0;
			// RL11: reads return stored bytes unchanged
			s_d.rdata = entry_word(s_q.table_mem[acc_entry], acc_word);
		end

		// The write lands on the edge where the master sees waitrequest low
		if (write && !s_q.waitreq) begin
			if (byteenable[`AF_LANE_EVEN]) begin
				s_d.table_mem[acc_entry][8*even_byte +: 8] = writedata[15:8];
			end
			if (byteenable[`AF_LANE_ODD]) begin
				s_d.table_mem[acc_entry][8*(even_byte+3'd1) +: 8] = writedata[7:0];
			end
			// RL9: mask writes leave entry state alone
			if (!(hash_enable && is_mask_entry(acc_entry))) begin
				// RL4: byte 5 re-enables, any earlier byte disables
				s_d.entry_live[acc_entry] =
					(acc_word == `AF_WORD_LAST) && byteenable[`AF_LANE_ODD];
			end
		end

		// ****************************************
		// Receive sequence
		// ****************************************
		if (!controller_enable) begin
			s_d.phase = RX_IDLE;
			s_d.bit_cnt = 6'd0;
		end else if (frame_start) begin
			s_d.phase = RX_COLLECT;
			s_d.bit_cnt = 6'd0;
		end else begin
			case (s_q.phase)
				RX_COLLECT: begin
					if (dest_bit_valid) begin
						// RL6: bits arrive byte 0 bit 0 first
						s_d.dest = {dest_bit, s_q.dest[47:1]};
						s_d.bit_cnt = 6'(s_q.bit_cnt + 6'd1);
						if (s_q.bit_cnt == `AF_DEST_LAST) begin
							s_d.phase = RX_EVAL;
						end
					end
				end
				RX_EVAL: begin
					// RL21: all decision fields updated in one cycle
					s_d.dec_valid = 1'b1;
					s_d.dec_accept = d_accept;
					s_d.dec_miss = d_miss;
					s_d.dec_reason = d_reason;
					s_d.dec_index = d_index;
					// RL19: pointer byte only when write-back is on
					s_d.ptr_write = index_writeback_enable && d_accept;
					s_d.ptr_byte = {d_reason, d_index};
					s_d.phase = RX_DONE;
				end
				RX_DONE: begin
					s_d.phase = RX_DONE;
				end
				default: begin
					s_d.phase = RX_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// The table has no defined content after reset; it is preset to all ones
	// and entry_live starts cleared, so an unfilled entry never matches
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_q.waitreq <= 1'b1;
			s_q.rdata <= `AF_RDATA_RESET;
			s_q.table_mem <= {64{`AF_ENTRY_RESET}};
			s_q.entry_live <= 64'h0000_0000_0000_0000;
			s_q.phase <= RX_IDLE;
			s_q.bit_cnt <= 6'd0;
			s_q.dest <= 48'h0000_0000_0000;
			s_q.dec_valid <= 1'b0;
			s_q.dec_accept <= 1'b0;
			s_q.dec_miss <= 1'b0;
			s_q.dec_reason <= `AF_REASON_NONE;
			s_q.dec_index <= `AF_INDEX_ZERO;
			s_q.ptr_write <= 1'b0;
			s_q.ptr_byte <= 8'h00;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign readdata = s_q.rdata;
	assign waitrequest = s_q.waitreq;
	assign decision_valid = s_q.dec_valid;
	assign frame_accept = s_q.dec_accept;
	assign frame_miss = s_q.dec_miss;
	assign accept_reason = s_q.dec_reason;
	assign accept_index = s_q.dec_index;
	assign pointer_write = s_q.ptr_write;
	assign pointer_byte = s_q.ptr_byte;

endmodule

/* File: logic/filter_decision.sv */
// Accept/reject decision from the match results and the receive controls
`timescale 1ns/1ps
`include "addr_filter_consts.svh"

module filter_decision
	import addr_filter_pkg::*;
(
	input wire logic is_broadcast,
	input wire logic is_group,
	input wire logic perfect_hit,
	input wire logic [5:0] perfect_line,
	input wire logic hash_hit,
	input wire logic [5:0] hash_index,
	input wire logic promiscuous_enable,
	input wire logic physical_reject_enable,
	input wire logic [1:0] group_frame_policy,
	output logic accept,
	output logic miss,
	output logic [1:0] reason,
	output logic [5:0] index
);

	function automatic logic [9:0] result(input logic a, input logic m, input logic [1:0] r,
		input logic [5:0] i);
		result = {a, m, r, i};
	endfunction

	logic [9:0] res;
	logic [9:0] take_perfect;
	logic [9:0] take_hash;
	logic [9:0] refuse;

	always_comb begin
		take_perfect = result(1'b1, 1'b0, `AF_REASON_PERFECT, perfect_line);
		take_hash = result(1'b1, 1'b0, `AF_REASON_HASH, hash_index);
		refuse = result(1'b0, 1'b0, `AF_REASON_NONE, `AF_INDEX_ZERO);
		res = refuse;
		if (is_broadcast) begin
			// RL15: broadcast by group policy
			if (!group_frame_policy[0]) begin
				res = result(1'b1, 1'b0, `AF_REASON_GROUP, `AF_INDEX_BCAST);
			end else if (promiscuous_enable) begin
				res = result(1'b1, 1'b1, `AF_REASON_NONE, `AF_INDEX_PROMISCUOUS_ENABLE_BCAST);
			end
		end else if (is_group) begin
			// RL16: multicast by policy
			if (group_frame_policy == 2'b11) begin
				if (promiscuous_enable) begin
					res = result(1'b1, 1'b1, `AF_REASON_NONE, hash_index);
				end
			end else if (perfect_hit) begin
				// RL18: perfect before hash
				res = take_perfect;
			end else if (hash_hit) begin
				res = take_hash;
			end else if (group_frame_policy[1]) begin
				res = result(1'b1, 1'b0, `AF_REASON_GROUP, `AF_INDEX_ZERO);
			end else if (promiscuous_enable) begin
				res = result(1'b1, 1'b1, `AF_REASON_NONE, hash_index);
			end
		end else if (!physical_reject_enable) begin
			// RL12: unicast normal filtering
			if (perfect_hit) begin
				res = take_perfect;
			end else if (hash_hit) begin
				res = take_hash;
			end else if (promiscuous_enable) begin
				// RL14: promiscuous catches misses
				res = result(1'b1, 1'b1, `AF_REASON_NONE, hash_index);
			end
		end else begin
			// RL13: physical reject inverts perfect
			if (perfect_hit) begin
				if (promiscuous_enable) begin
					// RL14: rejected perfect still taken
					res = result(1'b1, 1'b1, `AF_REASON_NONE, hash_index);
				end
			end else if (hash_hit) begin
				res = take_hash;
			end else begin
				res = result(1'b1, 1'b0, `AF_REASON_NONE, hash_index);
			end
		end
		{accept, miss, reason, index} = res;
	end

endmodule

/* File: logic/hash_crc_unit.sv */
// Serial CRC-32 over the destination address, giving the hash pointer
`timescale 1ns/1ps
`include "addr_filter_consts.svh"

module hash_crc_unit
	import addr_filter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic frame_start,
	input wire logic bit_take,
	input wire logic bit_value,
	output logic [5:0] hash_index
);

	crc_state_t s_q;
	crc_state_t s_d;

	// ****************************************
	// Generator
	// ****************************************
	// Only the 48 address bits are taken; the caller stops feeding after them
	always_comb begin
		logic fb;
		fb = 1'b0;
		s_d = s_q;
		if (frame_start) begin
			s_d.crc = `AF_CRC_INIT;
			s_d.running = 1'b1;
		end else if (bit_take && s_q.running) begin
			fb = s_q.crc[31] ^ bit_value;
			s_d.crc = {s_q.crc[30:0], 1'b0} ^ (fb ? `AF_CRC_POLY : 32'h0000_0000);
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{running: 1'b0, crc: `AF_CRC_INIT};
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// RL17: six top CRC bits
	assign hash_index = s_q.crc[31:26];

endmodule

/* File: tb/ethernet_address_filter_monitor.sv */
// Concurrent checks on the address filter ports
`timescale 1ns/1ps
module ethernet_address_filter_monitor (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic hash_enable,
	input wire logic controller_enable,
	input wire logic frame_start,
	input wire logic dest_bit_valid,
	input wire logic waitrequest,
	input wire logic decision_valid,
	input wire logic frame_accept,
	input wire logic frame_miss,
	input wire logic [1:0] accept_reason,
	input wire logic [5:0] accept_index,
	input wire logic pointer_write,
	input wire logic [7:0] pointer_byte
);
	logic [5:0] bits_q;
	logic hole;
	logic unmapped;
	// Spare words of the two mask entries are holes only in hash mode
	assign hole = hash_enable && address[7:3] == 5'h1f && address[1];
	assign unmapped = address[1:0] == 2'h3 || hole;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bits_q <= 6'h00;
		end else if (clk_en) begin
			if (frame_start || !controller_enable) bits_q <= 6'h00;
			else if (dest_bit_valid && bits_q != 6'h30) bits_q <= bits_q + 6'h01;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ****
	// Sequences
	// ****
	sequence s_mapped_req;
		(read || write) && waitrequest && clk_en && !unmapped;
	endsequence
	sequence s_last_bit;
		dest_bit_valid && clk_en && controller_enable && !frame_start && bits_q == 6'h2f;
	endsequence
	// ****
	// Assertions
	// ****
	bus_answer_time_a: assert property (s_mapped_req |=> !waitrequest)
		else $error("mapped access not answered after one cycle");
	ack_needs_req_a: assert property (!waitrequest |-> $past(read) || $past(write))
		else $error("acknowledge without a request");
	unused_silent_a: assert property ((read || write) && address[1:0] == 2'h3 |=> waitrequest)
		else $error("unused word acknowledged");
	hash_hole_silent_a: assert property ((read || write) && hole |=> waitrequest)
		else $error("hash mode hole acknowledged");
	decision_time_a: assert property (s_last_bit |=> !decision_valid ##1 decision_valid)
		else $error("decision not two cycles after last bit");
	decision_pulse_a: assert property (decision_valid |=> !decision_valid)
		else $error("decision strobe longer than one cycle");
	outputs_held_a: assert property (!decision_valid ##1 !decision_valid
		|-> $stable({frame_accept, frame_miss, accept_reason, accept_index}))
		else $error("decision outputs changed without strobe");
	pointer_byte_a: assert property (pointer_write |-> decision_valid && frame_accept
		&& pointer_byte == {accept_reason, accept_index})
		else $error("pointer byte wrong or written on reject");
	reject_fields_a: assert property (decision_valid && !frame_accept
		|-> !frame_miss && accept_reason == 2'b00 && accept_index == 6'h00)
		else $error("reject carries fields");
	miss_reason_a: assert property (decision_valid && frame_miss |-> accept_reason == 2'b00)
		else $error("miss with nonzero reason");
endmodule

/* File: tb/ethernet_address_filter_tb.sv */
// Self-checking bench for the address filter
`timescale 1ns/1ps
module ethernet_address_filter_tb;
	logic clk_sys, sys_rst, clk_en, read, write, controller_enable, hash_enable;
	logic promiscuous_enable, physical_reject_enable, index_writeback_enable;
	logic waitrequest, decision_valid, frame_accept, frame_miss, pointer_write;
	logic frame_start, dest_bit_valid, dest_bit;
	logic [1:0] byteenable, group_frame_policy, accept_reason;
	logic [5:0] accept_index;
	logic [7:0] address, pointer_byte;
	logic [15:0] writedata, readdata;
	logic [63:0] mask = 64'h0;
	logic [47:0] u1 = 48'h0a0b0c0d0e10, u2 = 48'h665544332212, u3 = 48'h998877665524;
	logic [47:0] u4 = 48'h121314151600, m1 = 48'h00005e000101, m2 = 48'h3c3c3c3c3c33;
	int n_errors = 0, num_checks = 0;
	ethernet_address_filter uut (.clk_sys, .sys_rst, .clk_en, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .controller_enable, .hash_enable,
		.promiscuous_enable, .physical_reject_enable, .group_frame_policy,
		.index_writeback_enable, .frame_start, .dest_bit_valid, .dest_bit, .decision_valid,
		.frame_accept, .frame_miss, .accept_reason, .accept_index, .pointer_write,
		.pointer_byte);
	frame_source src (.clk_sys, .frame_start, .dest_bit_valid, .dest_bit);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// ****
	// Compare, bus and frame tasks
	// ****
	task automatic chk_bus(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_dec(input string what, input logic [9:0] exp, input logic [9:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Unanswered requests are dropped after a bounded wait
	task automatic acc(input logic rd, input logic [7:0] a, input logic [15:0] d,
			input logic [1:0] be, input logic ok_exp);
		int n;
		n = 0;
		@(posedge clk_sys);
		read <= rd;
		write <= !rd;
		address <= a;
		writedata <= d;
		byteenable <= be;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 16);
		chk_bus("bus acknowledge", {15'h0, ok_exp}, {15'h0, waitrequest === 1'b0});
		if (rd && ok_exp) chk_bus("read data", d, readdata);
		read <= 1'b0;
		write <= 1'b0;
	endtask
	function automatic logic [15:0] word_of(input logic [47:0] x, input int w);
		return {x[16*w +: 8], x[16*w+8 +: 8]};
	endfunction
	task automatic put(input logic [5:0] e, input logic [47:0] x, input int words);
		for (int w = 0; w < words; w++) acc(0, {e, w[1:0]}, word_of(x, w), 2'b11, 1);
	endtask
	function automatic logic [5:0] hash6(input logic [47:0] x);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int k = 0; k < 48; k++) c = {c[30:0], 1'b0} ^ ((c[31] ^ x[k]) ? 32'h04c11db7 : 0);
		return c[31:26];
	endfunction
	function automatic logic [9:0] ex(input logic a, m, input logic [1:0] r, input logic [5:0] i);
		return a ? {a, m, r, i} : 10'h0;
	endfunction
	task automatic mask_byte(input int m);
		logic [7:0] b;
		b = mask[8*(7-m) +: 8];
		acc(0, (m < 4 ? 8'hf8 : 8'hfc) + 8'((m % 4) / 2), m[0] ? {8'h0, b} : {b, 8'h0},
			m[0] ? 2'b01 : 2'b10, 1);
	endtask
	task automatic frame(input logic [47:0] x, input logic [9:0] exp, input bit slow);
		int n;
		n = 0;
		src.send(x, slow);
		do begin
			@(posedge clk_sys);
			n++;
		end while (decision_valid !== 1'b1 && n < 8);
		chk_dec("decision strobe", 10'h1, {9'h0, decision_valid === 1'b1});
		chk_dec("decision", exp, {frame_accept, frame_miss, accept_reason, accept_index});
		chk_dec("pointer byte", {2'h0, exp[7:0]}, {2'h0, pointer_byte});
		chk_dec("pointer write", {9'h0, exp[9] & index_writeback_enable}, {9'h0, pointer_write});
	endtask
	task automatic results;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		results();
	end
	// ****
	// Test sequence
	// ****
	initial begin
		{sys_rst, clk_en, controller_enable} = 3'b111;
		{read, write, hash_enable, promiscuous_enable, physical_reject_enable} = 5'h0;
		{index_writeback_enable, group_frame_policy, byteenable} = 5'h0;
		address = 8'h00;
		writedata = 16'h0000;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		acc(1, 8'h14, 16'hffff, 2'b11, 1);
		put(0, u1, 3);
		put(1, m1, 3);
		put(2, u2, 3);
		acc(0, 8'h08, word_of(u2, 0), 2'b11, 1);
		frame(u2, 10'h0, 0);
		acc(0, 8'h0a, word_of(u2, 2), 2'b11, 1);
		frame(u2, ex(1, 0, 2'b10, 6'd2), 1);
		acc(0, 8'h00, 16'hee00, 2'b10, 1);
		frame(u1, 10'h0, 0);
		acc(1, 8'h00, {8'hee, u1[15:8]}, 2'b11, 1);
		acc(0, 8'h00, word_of(u1, 0), 2'b10, 1);
		acc(0, 8'h02, word_of(u1, 2), 2'b01, 1);
		frame(u1, ex(1, 0, 2'b10, 6'd0), 0);
		acc(1, 8'h05, word_of(m1, 1), 2'b11, 1);
		acc(1, 8'h03, 16'h0, 2'b11, 0);
		acc(0, 8'h07, 16'h0, 2'b11, 0);
		@(posedge clk_sys);
		hash_enable <= 1'b1;
		for (int m = 7; m >= 0; m--) mask_byte(m);
		mask[hash6(u3)] = 1'b1;
		mask_byte(7 - hash6(u3) / 8);
		mask[hash6(u1)] = 1'b1;
		mask_byte(7 - hash6(u1) / 8);
		acc(1, 8'hf8, mask[63:48], 2'b11, 1);
		frame(u3, ex(1, 0, 2'b11, hash6(u3)), 0);
		frame(u1, ex(1, 0, 2'b10, 6'd0), 0);
		for (int i = 0; i < 4; i++) acc(1, 8'hfa + 8'(4 * i[1] + i[0]), 16'h0, 2'b11, 0);
		for (int p = 0; p < 4; p++) begin
			@(posedge clk_sys);
			promiscuous_enable <= p[1];
			physical_reject_enable <= p[0];
			index_writeback_enable <= p[0];
			frame(u2, p[0] ? ex(p[1], 1, 0, hash6(u2)) : ex(1, 0, 2, 2), p[1]);
			frame(u3, ex(1, 0, 2'b11, hash6(u3)), 0);
			frame(u4, ex(p[1] | p[0], p[1] & ~p[0], 0, hash6(u4)), p[0]);
		end
		@(posedge clk_sys);
		hash_enable <= 1'b0;
		acc(1, 8'hfe, 16'hffff, 2'b11, 1);
		for (int p = 0; p < 8; p++) begin
			@(posedge clk_sys);
			promiscuous_enable <= p[2];
			physical_reject_enable <= 1'b0;
			group_frame_policy <= p[1:0];
			frame({48{1'b1}}, p[0] ? ex(p[2], 1, 0, 6'h2f) : ex(1, 0, 1, 6'h3f), p[1]);
			frame(m1, p[1:0] == 3 ? ex(p[2], 1, 0, hash6(m1)) : ex(1, 0, 2, 1), 0);
			frame(m2, p[1:0] == 2 ? ex(1, 0, 1, 0) : ex(p[2], 1, 0, hash6(m2)), 0);
		end
		results();
	end
endmodule
bind ethernet_address_filter ethernet_address_filter_monitor mon (.clk_sys, .sys_rst, .clk_en,
	.address, .read, .write, .hash_enable, .controller_enable, .frame_start, .dest_bit_valid,
	.waitrequest, .decision_valid, .frame_accept, .frame_miss, .accept_reason, .accept_index,
	.pointer_write, .pointer_byte);

/* File: tb/frame_source.sv */
// Receive bit stream source feeding destination addresses in wire order
`timescale 1ns/1ps
module frame_source (
	input wire logic clk_sys,
	output logic frame_start,
	output logic dest_bit_valid,
	output logic dest_bit
);
	initial begin
		frame_start = 1'b0;
		dest_bit_valid = 1'b0;
		dest_bit = 1'b0;
	end
	// ****
	// Frame transmission, prompt or with a gap after each bit
	// ****
	task automatic send(input logic [47:0] a, input bit slow);
		@(posedge clk_sys);
		frame_start <= 1'b1;
		for (int k = 0; k < 48; k++) begin
			@(posedge clk_sys);
			frame_start <= 1'b0;
			dest_bit <= a[k];
			dest_bit_valid <= 1'b1;
			if (slow) begin
				@(posedge clk_sys);
				dest_bit_valid <= 1'b0;
				// Idle line never shows a stale bit
				dest_bit <= ~a[k];
			end
		end
		@(posedge clk_sys);
		dest_bit_valid <= 1'b0;
		dest_bit <= ~a[47];
	endtask
endmodule
